// File: host_port_pkg.sv
// package for the host processor port of the multi-channel framer
// assumes a single 125 MHz system clock and synchronous active-low reset
package host_port_pkg;
  // ==========================================================================
  // address layout
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 8;
  localparam int CHAN_W      = 4;
  localparam int CHAN_LSB    = 8;
  localparam int REG_W       = 8;
  localparam int NUM_CHAN    = 12;
  localparam int NUM_REGS    = 4;
  // ==========================================================================
  // register offsets inside each channel block
  localparam logic [7:0] OFS_IDENT = 8'h00;
  localparam logic [7:0] OFS_CTRL  = 8'h01;
  localparam logic [7:0] OFS_IMASK = 8'h02;
  localparam logic [7:0] OFS_ISTAT = 8'h03;
  // ==========================================================================
  // reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] IMASK_RST = 8'h00;
  localparam logic [7:0] ISTAT_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // bus style select values
  localparam logic STYLE_SEPARATE = 1'b0;
  localparam logic STYLE_DSTROBE  = 1'b1;
endpackage : host_port_pkg

// File: host_sync2.sv
// two-flop synchroniser for one host-side level
// assumes the input is asynchronous to mclk
`timescale 1ns/1ns
module host_sync2
  import host_port_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
)
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // level in and out
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_r;

  // ==========================================================================
  // first stage feeds only the second stage
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      meta_r <= RST_VAL;
      q_out  <= RST_VAL;
    end
    else
    begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule : host_sync2

// File: host_cpu_bus_port.sv
// eight-bit host processor port with per-channel register blocks
// assumes host strobes are asynchronous and mclk runs without gaps
`timescale 1ns/1ns
// Function
// - static style input: low separate read/write strobes, high data strobe plus direction
// - data bus driven only during reads, bit 7 most significant
// - twelve-bit address, top four bits choose the channel
// - latch enable high makes the address latch transparent
// - latch enable falling captures address, held until enable rises
// - reads and writes happen only while chip select is low
// - separate style: write strobe writes, read strobe reads
// - data strobe style: one strobe times access, direction line picks read or write
// - open-drain interrupt low while any unmasked sticky status bit is set
// - host port timing comes from the system clock only
// - identity register readable at offset zero of every channel
// - undefined registers and bits read zero, writes ignored
module host_cpu_bus_port
  import host_port_pkg::*;
#(
  parameter int          CHANNELS = NUM_CHAN,
  parameter logic [7:0]  IDENTITY = 8'h5a  // arbitrary value
)
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // bus style and address
  input  wire logic                  strobe_style_select,
  input  wire logic [ADDR_W-1:0]     addr,
  input  wire logic                  addr_latch_en,
  // strobes, all active low
  input  wire logic                  chip_sel_n,
  input  wire logic                  write_n,
  input  wire logic                  access_strobe_n,
  // data bus split into three signals
  input  wire logic [DATA_W-1:0]     data_in,
  output logic      [DATA_W-1:0]     data_out,
  output logic                       data_oe_n,
  // interrupt sources per channel and open-drain output
  input  wire logic [CHANNELS*REG_W-1:0] irq_src,
  output logic                       irq_out,
  output logic                       irq_oe_n,
  // per-channel control register output
  output logic [CHANNELS*REG_W-1:0]  chan_ctrl
);
  logic              cs_s, wr_s, ds_s;
  logic [ADDR_W-1:0] addr_hold_r;
  logic [ADDR_W-1:0] addr_eff;
  logic [DATA_W-1:0] data_p1_r;
  logic [DATA_W-1:0] data_p2_r;
  logic [ADDR_W-1:0] addr_p1_r;
  logic [ADDR_W-1:0] addr_p2_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [CHAN_W-1:0] wchan;
  logic [7:0]        wofs;
  logic              wr_commit;
  logic              rd_act, wr_act, strobe_act;
  logic              strobe_d_r;
  logic              dir_read_r;
  logic [DATA_W-1:0] wdata_r;
  logic [CHAN_W-1:0] chan;
  logic [7:0]        ofs;
  logic [7:0]        rdata_nxt;
  logic [REG_W-1:0]  mask_r  [CHANNELS];
  logic [REG_W-1:0]  stat_r  [CHANNELS];
  logic [REG_W-1:0]  ctrl_r  [CHANNELS];
  logic              any_irq;
  logic              chan_ok;

  // ==========================================================================
  // synchronisers, everything timed from mclk only
  host_sync2 #(.RST_VAL(1'b1)) u_cs (.mclk(mclk), .reset_n(reset_n),
    .d_in(chip_sel_n), .q_out(cs_s));
  host_sync2 #(.RST_VAL(1'b1)) u_wr (.mclk(mclk), .reset_n(reset_n),
    .d_in(write_n), .q_out(wr_s));
  host_sync2 #(.RST_VAL(1'b1)) u_ds (.mclk(mclk), .reset_n(reset_n),
    .d_in(access_strobe_n), .q_out(ds_s));

  // ==========================================================================
  // address latch: transparent while enable high, held after falling edge
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      addr_hold_r <= '0;
    end
    else
    begin
      if (addr_latch_en)
        addr_hold_r <= addr;
    end
  end
  // held value covers the low phase; a fall freezes last transparent sample
  assign addr_eff = addr_latch_en ? addr : addr_hold_r;
  assign chan     = addr_eff[ADDR_W-1:CHAN_LSB];
  assign ofs      = addr_eff[CHAN_LSB-1:0];
  assign chan_ok  = (int'(chan) < CHANNELS);

  // ==========================================================================
  // data and address delayed by the synchroniser depth: the last sample taken
  // while the synced strobe is still active then predates the pin release,
  // so a host that drops its lines right after the strobe still writes cleanly
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      data_p1_r <= '0;
      data_p2_r <= '0;
      addr_p1_r <= '0;
      addr_p2_r <= '0;
    end
    else
    begin
      data_p1_r <= data_in;
      data_p2_r <= data_p1_r;
      addr_p1_r <= addr_eff;
      addr_p2_r <= addr_p1_r;
    end
  end

  // write target comes from the captured address, not the live pins
  assign wchan     = waddr_r[ADDR_W-1:CHAN_LSB];
  assign wofs      = waddr_r[CHAN_LSB-1:0];
  assign wr_commit = strobe_d_r && !strobe_act && !dir_read_r && (int'(wchan) < CHANNELS);

  // ==========================================================================
  // access decode by style
  always_comb
  begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    if (!cs_s)
    begin
      if (strobe_style_select == STYLE_SEPARATE)
      begin
        rd_act = !ds_s;
        wr_act = !wr_s;
      end
      else
      begin
        rd_act = !ds_s && wr_s;
        wr_act = !ds_s && !wr_s;
      end
    end
  end
  assign strobe_act = rd_act || wr_act;

  // ==========================================================================
  // remember direction and write data while the strobe is active
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      strobe_d_r <= 1'b0;
      dir_read_r <= 1'b1;
      wdata_r    <= '0;
      waddr_r    <= '0;
    end
    else
    begin
      strobe_d_r <= strobe_act;
      if (strobe_act)
      begin
        dir_read_r <= rd_act;
        wdata_r    <= data_p2_r;
        waddr_r    <= addr_p2_r;
      end
    end
  end

  // ==========================================================================
  // read mux; identity at offset zero of any channel, other undefined offsets and channels return zero
  always_comb
  begin
    rdata_nxt = READ_ZERO;
    if (ofs == OFS_IDENT)
      rdata_nxt = IDENTITY;
    else if (!chan_ok)
      rdata_nxt = READ_ZERO;
    else if (ofs == OFS_CTRL)
      rdata_nxt = ctrl_r[chan];
    else if (ofs == OFS_IMASK)
      rdata_nxt = mask_r[chan];
    else if (ofs == OFS_ISTAT)
      rdata_nxt = stat_r[chan];
  end

  // data bus driven only during a read
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      data_out  <= '0;
      data_oe_n <= 1'b1;
    end
    else
    begin
      data_out  <= rdata_nxt;
      data_oe_n <= !rd_act;
    end
  end

  // ==========================================================================
  // per-channel registers; write commits on the strobe's trailing edge
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        ctrl_r[i] <= CTRL_RST;
        mask_r[i] <= IMASK_RST;
        stat_r[i] <= ISTAT_RST;
      end
    end
    else
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        if (wr_commit && (int'(wchan) == i))
        begin
          if (wofs == OFS_CTRL)
            ctrl_r[i] <= wdata_r;
          else if (wofs == OFS_IMASK)
            mask_r[i] <= wdata_r;
        end
        // sticky status, write one to clear; a new source wins in the same cycle
        if (wr_commit && (int'(wchan) == i) && (wofs == OFS_ISTAT))
          stat_r[i] <= (stat_r[i] & ~wdata_r) | irq_src[i*REG_W +: REG_W];
        else
          stat_r[i] <= stat_r[i] | irq_src[i*REG_W +: REG_W];
      end
    end
  end

  // ==========================================================================
  // interrupt combine, open drain: output low, enable low while pulling
  always_comb
  begin
    any_irq = 1'b0;
    for (int i = 0; i < CHANNELS; i++)
      any_irq = any_irq | (|(stat_r[i] & mask_r[i]));
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      irq_oe_n <= 1'b1;
    else
      irq_oe_n <= !any_irq;
  end
  assign irq_out = 1'b0;

  // control registers out to the framers
  always_comb
  begin
    for (int i = 0; i < CHANNELS; i++)
      chan_ctrl[i*REG_W +: REG_W] = ctrl_r[i];
  end
endmodule : host_cpu_bus_port

// File: host_port_monitor.sv
// checker for the host port pins
// assumes one mclk domain, synchronous reset_n
`timescale 1ns/1ns
module host_port_monitor
  import host_port_pkg::*;
#(
  parameter int         CHANNELS = NUM_CHAN,
  parameter logic [7:0] IDENTITY = 8'h5a  // arbitrary value
)
(
  // inputs of the port
  input wire logic                      mclk,
  input wire logic                      reset_n,
  input wire logic                      strobe_style_select,
  input wire logic [ADDR_W-1:0]         addr,
  input wire logic                      addr_latch_en,
  input wire logic                      chip_sel_n,
  input wire logic                      write_n,
  input wire logic                      access_strobe_n,
  // outputs of the port
  input wire logic [DATA_W-1:0]         data_out,
  input wire logic                      data_oe_n,
  input wire logic                      irq_out,
  input wire logic                      irq_oe_n,
  input wire logic [CHANNELS*REG_W-1:0] chan_ctrl
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // read drive: two sync flops put the cause two edges back
  a_oe_cs_low: assert property ($fell(data_oe_n) |-> !$past(chip_sel_n, 2))
    else $error("bus driven without select");
  a_oe_strobe_low: assert property ($fell(data_oe_n) |-> !$past(access_strobe_n, 2))
    else $error("bus driven without read strobe");
  a_oe_dir_read: assert property ($fell(data_oe_n) && strobe_style_select |-> $past(write_n, 2))
    else $error("bus driven on a write");
  a_oe_strobe_idle: assert property (access_strobe_n [*4] |-> data_oe_n)
    else $error("bus still driven after strobe");
  // ==========================================================
  // read data; only with a transparent, steady address
  a_read_ident: assert property (!data_oe_n && addr_latch_en && $stable(addr) && addr[7:0] == OFS_IDENT
    |-> data_out == IDENTITY) else $error("identity read wrong");
  a_read_zero: assert property (!data_oe_n && addr_latch_en && $stable(addr) && addr[7:0] != OFS_IDENT
    && (addr[11:8] >= CHANNELS || addr[7:0] > OFS_ISTAT) |-> data_out == READ_ZERO) else $error("reserved read");
  // ==========================================================
  // interrupt pin and write commit
  a_irq_pull_low: assert property (!irq_oe_n |-> irq_out == 1'b0)
    else $error("interrupt not pulled low");
  a_irq_release_write: assert property ($rose(irq_oe_n) |-> !$past(chip_sel_n, 5))
    else $error("interrupt released without a write");
  a_ctrl_on_release: assert property ($changed(chan_ctrl) |-> $past(chip_sel_n)
    && (!$past(chip_sel_n, 4) || !$past(chip_sel_n, 5))) else $error("control changed off a write");
endmodule : host_port_monitor

// File: host_model.sv
// host processor model for both strobe styles
// assumes pins change at the falling edge of mclk
`timescale 1ns/1ns
module host_model
  import host_port_pkg::*;
(
  // clock and style
  input wire logic               mclk,
  input wire logic               style,
  // bus pins
  output logic [ADDR_W-1:0]      addr,
  output logic                   ale,
  output logic                   cs_n,
  output logic                   wr_n,
  output logic                   strb_n,
  output logic [DATA_W-1:0]      wdata,
  input wire logic [DATA_W-1:0]  rdata
);
  // idle bus: deselected, latch open
  initial
  begin
    addr = 12'h000;
    ale = 1'b1;
    cs_n = 1'b1;
    wr_n = 1'b1;
    strb_n = 1'b1;
    wdata = 8'h00;
  end
  // one access, held for six cycles so the synchronisers see it
  task automatic access(input logic sel, input logic wr, input logic mux,
                        input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge mclk);
    addr = a;
    ale = 1'b1;
    if (mux)
    begin
      @(negedge mclk);
      ale = 1'b0;
      @(negedge mclk);
      addr = ~a;  // shared lines now carry other traffic
    end
    cs_n = !sel;
    wdata = wr ? d : ~wdata;
    if (style)
    begin
      wr_n = !wr;
      strb_n = 1'b0;
    end
    else if (wr)
      wr_n = 1'b0;
    else
      strb_n = 1'b0;
    repeat (5) @(negedge mclk);
    q = rdata;  // settled since the third edge after the strobe fell
    @(negedge mclk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    strb_n = 1'b1;
    wdata = ~wdata;  // released lines must not keep the last byte
    addr = ~addr;
    repeat (6) @(negedge mclk);
  endtask : access
endmodule : host_model

// File: tb.sv
// bench for the host port: access table, then interrupt and reset cases
// assumes the host model owns every bus pin
`timescale 1ns/1ns
module tb
  import host_port_pkg::*;
;
  localparam logic [7:0] ID_VAL = 8'h5a;  // arbitrary value
  typedef struct packed {logic s, c, w, m; logic [11:0] a; logic [7:0] d, e;} row_s;
  logic        mclk, reset_n, style, ale, cs_n, wr_n, strb_n, data_oe_n, irq_out, irq_oe_n;
  logic [11:0] addr;
  logic [7:0]  wdata, data_out, q;
  logic [95:0] irq_src, chan_ctrl;
  int          n_fail, checks_done, cycles;
  // style, select, write, muxed, address, data, expected read
  row_s rows [14] = '{
    '{1'b0,1'b1,1'b1,1'b0,12'h101,8'ha5,8'h00}, '{1'b0,1'b1,1'b0,1'b0,12'h101,8'h00,8'ha5},
    '{1'b1,1'b1,1'b1,1'b0,12'h201,8'h3c,8'h00}, '{1'b1,1'b1,1'b0,1'b0,12'h201,8'h00,8'h3c},
    '{1'b1,1'b1,1'b0,1'b0,12'h100,8'h00,ID_VAL}, '{1'b0,1'b1,1'b0,1'b0,12'hb00,8'h00,ID_VAL},
    '{1'b1,1'b1,1'b0,1'b0,12'hc01,8'h00,READ_ZERO}, '{1'b0,1'b1,1'b0,1'b0,12'h105,8'h00,READ_ZERO},
    '{1'b1,1'b1,1'b1,1'b0,12'hc01,8'hff,8'h00}, '{1'b0,1'b1,1'b1,1'b1,12'h301,8'h77,8'h00},
    '{1'b1,1'b1,1'b0,1'b1,12'h301,8'h00,8'h77}, '{1'b0,1'b1,1'b1,1'b0,12'h100,8'hee,8'h00},
    '{1'b0,1'b1,1'b0,1'b0,12'h100,8'h00,ID_VAL}, '{1'b1,1'b0,1'b1,1'b0,12'h401,8'h99,8'h00}};
  host_cpu_bus_port #(.CHANNELS(12), .IDENTITY(ID_VAL)) dut_u (.mclk(mclk), .reset_n(reset_n),
    .strobe_style_select(style), .addr(addr), .addr_latch_en(ale), .chip_sel_n(cs_n), .write_n(wr_n),
    .access_strobe_n(strb_n), .data_in(wdata), .data_out(data_out), .data_oe_n(data_oe_n), .irq_src(irq_src),
    .irq_out(irq_out), .irq_oe_n(irq_oe_n), .chan_ctrl(chan_ctrl));
  host_model host_u (.mclk(mclk), .style(style), .addr(addr), .ale(ale), .cs_n(cs_n), .wr_n(wr_n),
    .strb_n(strb_n), .wdata(wdata), .rdata(data_out));
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      end_sim();
    end
  end
  initial
  begin
    reset_n = 1'b0;
    style = 1'b0;
    irq_src = '0;
    repeat (8) @(negedge mclk);
    chk(data_oe_n, 1'b1);
    chk(irq_oe_n, 1'b1);
    reset_n = 1'b1;
    foreach (rows[i])
    begin
      style = rows[i].s;
      host_u.access(rows[i].c, rows[i].w, rows[i].m, rows[i].a, rows[i].d, q);
      if (rows[i].c && !rows[i].w)
        chk(q, rows[i].e);
    end
    chk(chan_ctrl, 96'h773ca500);
    // sticky source, then mask both ways: exactly one setting pulls the pin
    irq_src[0] = 1'b1;
    repeat (2) @(negedge mclk);
    irq_src[0] = 1'b0;
    host_u.access(1'b1, 1'b0, 1'b0, 12'h003, 8'h00, q);
    chk(q, 8'h01);
    host_u.access(1'b1, 1'b1, 1'b0, 12'h002, 8'h00, q);
    chk(irq_oe_n, 1'b1);
    host_u.access(1'b1, 1'b1, 1'b0, 12'h002, 8'hff, q);
    chk(irq_oe_n, 1'b0);
    host_u.access(1'b1, 1'b1, 1'b0, 12'h003, 8'h01, q);
    chk(irq_oe_n, 1'b1);
    // reset again in mid-run clears the control registers
    reset_n = 1'b0;
    repeat (8) @(negedge mclk);
    chk(chan_ctrl, 96'h0);
    reset_n = 1'b1;
    // first access after the second release reads the cleared control value
    host_u.access(1'b1, 1'b0, 1'b0, 12'h301, 8'h00, q);
    chk(q, CTRL_RST);
    end_sim();
  end
endmodule : tb
bind host_cpu_bus_port host_port_monitor #(.CHANNELS(CHANNELS), .IDENTITY(IDENTITY)) mon_u (.mclk(mclk),
  .reset_n(reset_n), .strobe_style_select(strobe_style_select), .addr(addr), .addr_latch_en(addr_latch_en),
  .chip_sel_n(chip_sel_n), .write_n(write_n), .access_strobe_n(access_strobe_n), .data_out(data_out),
  .data_oe_n(data_oe_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n), .chan_ctrl(chan_ctrl));
